// ===== src/cfdt_pkg.sv
/*
 * Shared constants and types for the flag and data-transfer execution unit.
 * Assumes a front end that hands over one decoded command at a time.
 */
package cfdt_pkg;

    // Bit positions inside the flags register.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [15:0] SP_RESET    = 16'hffff;  // Arbitrary start of the stack.
    localparam logic [15:0] PTR_STEP    = 16'h0001;

    // Clock counts of each instruction class.
    localparam int CYC_FLAG = 1;
    localparam int CYC_MEM  = 2;
    localparam int CYC_PMEM = 3;

    // Register file indices of the low bytes of the pointers, and of R0.
    localparam logic [4:0] REG_R0 = 5'h00;
    localparam logic [4:0] REG_X  = 5'h1a;
    localparam logic [4:0] REG_Y  = 5'h1c;
    localparam logic [4:0] REG_Z  = 5'h1e;
    localparam logic [4:0] EVEN_MASK = 5'h1e;

    typedef enum logic [4:0] {
        OP_NOP                   = 5'h00,
        OP_INTERRUPTS_OFF        = 5'h01,
        OP_SIGNED_FLAG_ON        = 5'h02,
        OP_SIGNED_FLAG_OFF       = 5'h03,
        OP_OVERFLOW_FLAG_ON      = 5'h04,
        OP_OVERFLOW_FLAG_OFF     = 5'h05,
        OP_TRANSFER_BIT_ON       = 5'h06,
        OP_TRANSFER_BIT_OFF      = 5'h07,
        OP_HALF_CARRY_ON         = 5'h08,
        OP_HALF_CARRY_OFF        = 5'h09,
        OP_REGISTER_COPY         = 5'h0a,
        OP_REGISTER_PAIR_COPY    = 5'h0b,
        OP_IMMEDIATE_LOAD        = 5'h0c,
        OP_LOAD_INDIRECT         = 5'h0d,
        OP_READ_WITH_OFFSET      = 5'h0e,
        OP_READ_DIRECT           = 5'h0f,
        OP_WRITE_INDIRECT        = 5'h10,
        OP_WRITE_WITH_OFFSET     = 5'h11,
        OP_WRITE_DIRECT          = 5'h12,
        OP_PROGRAM_MEMORY_READ   = 5'h13,
        OP_PUSH                  = 5'h14,
        OP_POP                   = 5'h15,
        OP_BREAK                 = 5'h16
    } cfdt_op_e;

    typedef enum logic [1:0] {
        PTR_X = 2'b00,
        PTR_Y = 2'b01,
        PTR_Z = 2'b10
    } cfdt_ptr_e;

    typedef enum logic [1:0] {
        AM_PLAIN   = 2'b00,
        AM_POSTINC = 2'b01,
        AM_PREDEC  = 2'b10
    } cfdt_mode_e;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_MEM  = 2'b01,
        S_PM1  = 2'b10,
        S_PM2  = 2'b11
    } cfdt_state_e;

    // One decoded command; imm holds K, a direct address or the offset q.
    typedef struct packed {
        cfdt_op_e   op;
        cfdt_ptr_e  ptr;
        cfdt_mode_e mode;
        logic       use_r0;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [15:0] imm;
    } cfdt_cmd_s;

    // Request towards data memory and stack.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        re;
        logic        we;
    } cfdt_dmreq_s;

endpackage : cfdt_pkg

// ===== src/cfdt_regfile.sv
/*
 * Thirty-two byte working registers with one byte-or-word write port.
 * Assumes word writes target an even index; pointers are the top three pairs.
 */
`timescale 1ns/1ps
module cfdt_regfile #(
    parameter int NREGS = 32
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        we,
    input  wire logic        wide,
    input  wire logic [4:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [4:0]  raddr,
    output logic      [7:0]  rbyte,
    output logic      [15:0] rword,
    output logic      [15:0] x_ptr,
    output logic      [15:0] y_ptr,
    output logic      [15:0] z_ptr
);
    import cfdt_pkg::*;

    logic [7:0] regs_q [NREGS];
    logic [4:0] even_addr;
    logic [4:0] odd_addr;

    // Index pairs for word reads.
    assign even_addr = raddr & EVEN_MASK;
    assign odd_addr  = even_addr | 5'h01;

    // Read data come straight from the storage flops.
    assign rbyte = regs_q[raddr];
    assign rword = {regs_q[odd_addr], regs_q[even_addr]};
    assign x_ptr = {regs_q[REG_X | 5'h01], regs_q[REG_X]};
    assign y_ptr = {regs_q[REG_Y | 5'h01], regs_q[REG_Y]};
    assign z_ptr = {regs_q[REG_Z | 5'h01], regs_q[REG_Z]};

    // Byte writes touch one register, word writes the even and odd pair.
    always_ff @(posedge clk) begin
        for (int i = 0; i < NREGS; i++) begin
            if (rst) begin
                regs_q[i] <= 8'h00;
            end else if (we && !wide && waddr == i[4:0]) begin
                regs_q[i] <= wdata[7:0];
            end else if (we && wide && (waddr & EVEN_MASK) == i[4:0]) begin
                regs_q[i] <= wdata[7:0];
            end else if (we && wide && ((waddr & EVEN_MASK) | 5'h01) == i[4:0]) begin
                regs_q[i] <= wdata[15:8];
            end
        end
    end

endmodule : cfdt_regfile

// ===== src/cfdt_core.sv
/*
 * Execution unit for the flag set/clear group and the data-transfer group.
 * Assumes data memory answers combinationally while dm read strobe is high,
 * and program memory likewise while pm read strobe is high.
 */
// Notes on behaviour
// - Overflow on/off: V only, one clock.
// - Signed flag on/off: S only, one clock.
// - Half carry and T on/off: own bit.
// - Post-increment load reads, then pointer plus one.
// - Pre-decrement load: pointer minus one, then read.
// - Offset load: Y/Z plus q, pointer kept.
// - Post-increment store writes, then pointer plus one.
// - Pre-decrement store: pointer minus one, then write.
// - Offset store: Y/Z plus q, pointer kept.
// - Direct load from constant address, two clocks.
// - Direct store to constant address, two clocks.
// - Program read via Z, default R0, three clocks.
// - Push stores register, two clocks, flags kept.
// - Pop loads register, two clocks, flags kept.
// - Break only signals debug, no normal effect.
`timescale 1ns/1ps
module cfdt_core #(
    parameter logic [15:0] SP_INIT = 16'hffff
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   cmd_valid,
    input  wire cfdt_pkg::cfdt_cmd_s    cmd,
    input  wire logic                   debug_en,
    input  wire logic [7:0]             dm_rdata,
    input  wire logic [7:0]             pm_rdata,
    output logic                        ready_q,
    output logic                        done_q,
    output logic                        break_q,
    output cfdt_pkg::cfdt_dmreq_s       dm_q,
    output logic [15:0]                 pm_addr_q,
    output logic                        pm_re_q,
    output logic [7:0]                  flags_register_q
);
    import cfdt_pkg::*;

    cfdt_state_e state_q, state_d;
    logic [15:0] sp_q;
    logic [4:0]  dst_q;
    logic        load_q;
    logic [7:0]  pm_data_q;
    logic [15:0] x_ptr, y_ptr, z_ptr;
    logic [7:0]  rr_byte;
    logic [15:0] rr_word;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the offered command.
    wire accept      = (state_q == S_IDLE) && cmd_valid;
    wire is_ind_ld   = cmd.op == OP_LOAD_INDIRECT;
    wire is_ind_st   = cmd.op == OP_WRITE_INDIRECT;
    wire is_ind      = is_ind_ld || is_ind_st;
    wire is_off      = cmd.op == OP_READ_WITH_OFFSET || cmd.op == OP_WRITE_WITH_OFFSET;
    wire is_dir      = cmd.op == OP_READ_DIRECT || cmd.op == OP_WRITE_DIRECT;
    wire is_stack    = cmd.op == OP_PUSH || cmd.op == OP_POP;
    wire is_pmr      = cmd.op == OP_PROGRAM_MEMORY_READ;
    wire is_dm_op    = is_ind || is_off || is_dir || is_stack;
    wire is_load     = is_ind_ld || cmd.op == OP_READ_WITH_OFFSET
                       || cmd.op == OP_READ_DIRECT || cmd.op == OP_POP;
    wire is_copy     = cmd.op == OP_REGISTER_COPY || cmd.op == OP_REGISTER_PAIR_COPY
                       || cmd.op == OP_IMMEDIATE_LOAD;
    wire is_transfer = is_dm_op || is_pmr || is_copy;

    ////////////////////////////////////////////////////////////////////////
    // Pointer selection and address arithmetic.
    wire [15:0] ptr_val  = (cmd.ptr == PTR_X) ? x_ptr : (cmd.ptr == PTR_Y) ? y_ptr : z_ptr;
    wire [4:0]  ptr_reg  = (cmd.ptr == PTR_X) ? REG_X : (cmd.ptr == PTR_Y) ? REG_Y : REG_Z;
    wire [15:0] ptr_inc  = ptr_val + PTR_STEP;
    wire [15:0] ptr_dec  = ptr_val - PTR_STEP;
    wire [15:0] ind_addr = (cmd.mode == AM_PREDEC) ? ptr_dec : ptr_val;
    wire [15:0] off_ptr  = (cmd.ptr == PTR_Y) ? y_ptr : z_ptr;
    wire [15:0] off_addr = off_ptr + {10'h000, cmd.imm[5:0]};
    wire [15:0] sp_next  = (cmd.op == OP_PUSH) ? sp_q - PTR_STEP : sp_q + PTR_STEP;
    wire [15:0] stk_addr = (cmd.op == OP_PUSH) ? sp_q : sp_q + PTR_STEP;
    wire [15:0] dm_addr  = is_ind ? ind_addr : is_off ? off_addr
                           : is_stack ? stk_addr : cmd.imm;
    wire        ptr_step = (is_ind && cmd.mode != AM_PLAIN)
                           || (is_pmr && cmd.mode == AM_POSTINC);
    wire [15:0] ptr_new  = (cmd.mode == AM_PREDEC) ? ptr_dec : ptr_inc;

    ////////////////////////////////////////////////////////////////////////
    // Flag operations: each touches only its own bit.
    logic [7:0] flags_d;
    always_comb begin
        flags_d = flags_register_q;
        if (accept) begin
            case (cmd.op)
                OP_INTERRUPTS_OFF:    flags_d[FLAG_I] = 1'b0;
                OP_SIGNED_FLAG_ON:    flags_d[FLAG_S] = 1'b1;
                OP_SIGNED_FLAG_OFF:   flags_d[FLAG_S] = 1'b0;
                OP_OVERFLOW_FLAG_ON:  flags_d[FLAG_V] = 1'b1;
                OP_OVERFLOW_FLAG_OFF: flags_d[FLAG_V] = 1'b0;
                OP_TRANSFER_BIT_ON:   flags_d[FLAG_T] = 1'b1;
                OP_TRANSFER_BIT_OFF:  flags_d[FLAG_T] = 1'b0;
                OP_HALF_CARRY_ON:     flags_d[FLAG_H] = 1'b1;
                OP_HALF_CARRY_OFF:    flags_d[FLAG_H] = 1'b0;
                default:              flags_d = flags_register_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file write port: copies and pointer steps at accept, loaded
    // bytes in the last cycle of a transfer.
    logic        rf_we;
    logic        rf_wide;
    logic [4:0]  rf_waddr;
    logic [15:0] rf_wdata;
    always_comb begin
        rf_we    = 1'b0;
        rf_wide  = 1'b0;
        rf_waddr = cmd.rd;
        rf_wdata = {8'h00, cmd.imm[7:0]};
        if (state_q == S_MEM && load_q) begin
            rf_we    = 1'b1;
            rf_waddr = dst_q;
            rf_wdata = {8'h00, dm_rdata};
        end else if (state_q == S_PM2) begin
            rf_we    = 1'b1;
            rf_waddr = dst_q;
            rf_wdata = {8'h00, pm_data_q};
        end else if (accept && ptr_step) begin
            rf_we    = 1'b1;
            rf_wide  = 1'b1;
            rf_waddr = is_pmr ? REG_Z : ptr_reg;
            rf_wdata = is_pmr ? z_ptr + PTR_STEP : ptr_new;
        end else if (accept && is_copy) begin
            rf_we    = 1'b1;
            rf_wide  = cmd.op == OP_REGISTER_PAIR_COPY;
            rf_wdata = (cmd.op == OP_REGISTER_COPY) ? {8'h00, rr_byte}
                     : (cmd.op == OP_REGISTER_PAIR_COPY) ? rr_word : {8'h00, cmd.imm[7:0]};
        end
    end

    cfdt_regfile #(
        .NREGS (32)
    ) u_regs (
        .clk   (clk),
        .rst   (rst),
        .we    (rf_we),
        .wide  (rf_wide),
        .waddr (rf_waddr),
        .wdata (rf_wdata),
        .raddr (cmd.rr),
        .rbyte (rr_byte),
        .rword (rr_word),
        .x_ptr (x_ptr),
        .y_ptr (y_ptr),
        .z_ptr (z_ptr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one cycle for flags and copies, two for data memory and
    // stack, three for program memory.
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (accept && is_dm_op) begin
                    state_d = S_MEM;
                end else if (accept && is_pmr) begin
                    state_d = S_PM1;
                end
            end
            S_MEM:   state_d = S_IDLE;
            S_PM1:   state_d = S_PM2;
            S_PM2:   state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // State, flags and stack pointer.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q          <= S_IDLE;
            flags_register_q <= FLAGS_RESET;
            sp_q             <= SP_INIT;
            ready_q          <= 1'b1;
        end else begin
            state_q          <= state_d;
            flags_register_q <= flags_d;
            ready_q          <= state_d == S_IDLE;
            if (accept && is_stack) begin
                sp_q <= sp_next;
            end
        end
    end

    // Memory strobes and destination bookkeeping.
    always_ff @(posedge clk) begin
        if (rst) begin
            dm_q      <= '0;
            pm_addr_q <= 16'h0000;
            pm_re_q   <= 1'b0;
            dst_q     <= 5'h00;
            load_q    <= 1'b0;
            pm_data_q <= 8'h00;
        end else begin
            dm_q.re <= accept && is_dm_op && is_load;
            dm_q.we <= accept && is_dm_op && !is_load;
            pm_re_q <= accept && is_pmr;
            if (accept) begin
                dm_q.addr  <= dm_addr;
                dm_q.wdata <= rr_byte;
                pm_addr_q  <= z_ptr;
                dst_q      <= (is_pmr && cmd.use_r0) ? REG_R0 : cmd.rd;
                load_q     <= is_load;
            end
            if (state_q == S_PM1) begin
                pm_data_q <= pm_rdata;
            end
        end
    end

    // Completion pulse and the debug-only break signal.
    always_ff @(posedge clk) begin
        if (rst) begin
            done_q  <= 1'b0;
            break_q <= 1'b0;
        end else begin
            done_q  <= (accept && !is_dm_op && !is_pmr) || state_q == S_MEM
                       || state_q == S_PM2;
            break_q <= accept && cmd.op == OP_BREAK && debug_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_overflow_only: assert property (
        accept && (cmd.op == OP_OVERFLOW_FLAG_ON || cmd.op == OP_OVERFLOW_FLAG_OFF)
        |=> flags_register_q[FLAG_V] == ($past(cmd.op) == OP_OVERFLOW_FLAG_ON)
            && flags_register_q[7:4] == $past(flags_register_q[7:4])
            && flags_register_q[2:0] == $past(flags_register_q[2:0]) && ready_q)
        else $error("overflow flag op wrong");

    a_signed_only: assert property (
        accept && (cmd.op == OP_SIGNED_FLAG_ON || cmd.op == OP_SIGNED_FLAG_OFF)
        |=> flags_register_q[FLAG_S] == ($past(cmd.op) == OP_SIGNED_FLAG_ON)
            && (flags_register_q & 8'hef) == ($past(flags_register_q) & 8'hef))
        else $error("signed flag op wrong");

    a_half_t_only: assert property (
        accept && (cmd.op inside {OP_HALF_CARRY_ON, OP_HALF_CARRY_OFF,
                                  OP_TRANSFER_BIT_ON, OP_TRANSFER_BIT_OFF})
        |=> ((flags_register_q ^ $past(flags_register_q)) & 8'h9f) == 8'h00
            && done_q && ready_q)
        else $error("half carry or T op wrong");

    a_mem_two_clk: assert property (
        accept && is_dm_op |=> (dm_q.re || dm_q.we) && !ready_q ##1 ready_q && done_q)
        else $error("data memory op not two clocks");

    a_postinc_ptr: assert property (
        accept && is_ind && cmd.mode == AM_POSTINC && cmd.ptr == PTR_Z
        |=> dm_q.addr == $past(ptr_val) && z_ptr == $past(ptr_val) + PTR_STEP)
        else $error("post-increment wrong");

    a_predec_addr: assert property (
        accept && is_ind && cmd.mode == AM_PREDEC
        |=> dm_q.addr == $past(ptr_val) - PTR_STEP)
        else $error("pre-decrement address wrong");

    a_offset_keep: assert property (
        accept && is_off |=> dm_q.addr == $past(off_ptr) + {10'h000, $past(cmd.imm[5:0])}
            && $stable(y_ptr) && $stable(z_ptr))
        else $error("offset access wrong");

    a_direct_addr: assert property (
        accept && is_dir |=> dm_q.addr == $past(cmd.imm))
        else $error("direct address wrong");

    a_pmr_three: assert property (
        accept && is_pmr |=> pm_re_q && pm_addr_q == $past(z_ptr) ##1 !ready_q ##1 done_q)
        else $error("program read not three clocks");

    a_flags_kept: assert property (
        accept && is_transfer |=> $stable(flags_register_q)
            ##1 ($stable(flags_register_q) || $past(ready_q)))
        else $error("transfer changed flags");

    a_break_quiet: assert property (
        accept && cmd.op == OP_BREAK |=> break_q == $past(debug_en) && !dm_q.we
            && !dm_q.re && $stable(flags_register_q))
        else $error("break had side effect");

    c_pmr_postinc: cover property (accept && is_pmr && cmd.mode == AM_POSTINC ##3 done_q);
    c_pop_done:    cover property (accept && cmd.op == OP_POP ##2 done_q);
    c_flag_burst:  cover property (accept && cmd.op == OP_SIGNED_FLAG_ON ##1
                                   accept && cmd.op == OP_OVERFLOW_FLAG_OFF);

endmodule : cfdt_core

// ===== sim/cfdt_mem_model.sv
/*
 * Data memory, stack and program memory seen by the execution unit.
 * Assumes the unit's one-cycle read and write strobes on the rising edge of clk.
 */
`timescale 1ns/1ps
module cfdt_mem_model
    import cfdt_pkg::*;
(
    input  wire logic        clk,
    input  wire cfdt_dmreq_s dm,
    input  wire logic [15:0] pm_addr,
    input  wire logic        pm_re,
    output logic      [7:0]  dm_rdata,
    output logic      [7:0]  pm_rdata
);
    logic [7:0] mem [logic [15:0]];
    logic [7:0] dm_last = 8'h00;
    logic [7:0] pm_last = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Unwritten bytes follow a fixed pattern; an idle bus shows the inverse of
    // its last value, so a late sample never passes by luck.
    always @* begin
        if (dm.re) begin
            dm_rdata = mem.exists(dm.addr) ? mem[dm.addr] : (dm.addr[7:0] ^ dm.addr[15:8] ^ 8'h5a);
        end else begin
            dm_rdata = ~dm_last;
        end
        pm_rdata = pm_re ? (pm_addr[7:0] + pm_addr[15:8] + 8'h3c) : ~pm_last;
    end

    // Writes land and idle values are remembered at the strobe's edge.
    always @(posedge clk) begin
        if (dm.we) begin
            mem[dm.addr] = dm.wdata;
        end
        if (dm.re) begin
            dm_last <= dm_rdata;
        end
        if (pm_re) begin
            pm_last <= pm_rdata;
        end
    end
endmodule : cfdt_mem_model

// ===== sim/tb_cpu_flag_and_data_transfer_ops.sv
/*
 * Self-checking bench for the flag and data-transfer execution unit.
 * Assumes the memory model answers reads combinationally.
 */
`timescale 1ns/1ps
module tb_cpu_flag_and_data_transfer_ops;
    import cfdt_pkg::*;
    typedef struct packed {
        logic [7:0]  flags;
        logic        re;
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wd;
        logic        pre;
        logic [15:0] pa;
        logic        brk;
        logic [3:0]  lat;
    } cfdt_exp_s;
    localparam logic [15:0] SP_TB = 16'h0800;
    logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, debug_en = 1'b0;
    cfdt_cmd_s   cmd = '0;
    logic        ready_q, done_q, break_q, pm_re_q;
    cfdt_dmreq_s dm_q;
    logic [7:0]  dm_rdata, pm_rdata, flags_register_q, fl, s_wd;
    logic [15:0] pm_addr_q, sp, s_addr, s_pa;
    logic        s_re = 1'b0, s_we = 1'b0, s_pre = 1'b0, s_brk = 1'b0;
    logic [7:0]  rg [32];
    logic [7:0]  mir [logic [15:0]];
    cfdt_exp_s   exp_q [$];
    int          acc_q [$];
    int          err_count = 0, n_tests = 0, cyc = 0;

    always #5 clk = ~clk;

    cfdt_core #(.SP_INIT(SP_TB)) cfdt_core_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .debug_en(debug_en), .dm_rdata(dm_rdata), .pm_rdata(pm_rdata),
        .ready_q(ready_q), .done_q(done_q), .break_q(break_q), .dm_q(dm_q),
        .pm_addr_q(pm_addr_q), .pm_re_q(pm_re_q), .flags_register_q(flags_register_q));
    cfdt_mem_model cfdt_mem_model_i (.clk(clk), .dm(dm_q), .pm_addr(pm_addr_q), .pm_re(pm_re_q),
        .dm_rdata(dm_rdata), .pm_rdata(pm_rdata));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        if (seen !== expd) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask : check

    task automatic wrap_up();
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // Reference of registers, flags, stack and memory; returns what must show.
    function automatic cfdt_exp_s ref_exec(input cfdt_cmd_s c, input logic dbg);
        cfdt_exp_s e;
        logic [4:0] pi;
        logic [15:0] p, a;
        logic ld, st;
        e = '0;
        e.lat = 4'h1;
        ld = c.op inside {OP_LOAD_INDIRECT, OP_READ_WITH_OFFSET, OP_READ_DIRECT, OP_POP};
        st = c.op inside {OP_WRITE_INDIRECT, OP_WRITE_WITH_OFFSET, OP_WRITE_DIRECT, OP_PUSH};
        pi = (c.ptr == PTR_X) ? REG_X : (c.ptr == PTR_Y) ? REG_Y : REG_Z;
        if ((c.op inside {OP_READ_WITH_OFFSET, OP_WRITE_WITH_OFFSET} && c.ptr == PTR_X)
            || c.op == OP_PROGRAM_MEMORY_READ) pi = REG_Z;
        p = {rg[pi + 1], rg[pi]};
        a = p;
        case (c.op)
            OP_INTERRUPTS_OFF:    fl[FLAG_I] = 1'b0;
            OP_SIGNED_FLAG_ON:    fl[FLAG_S] = 1'b1;
            OP_SIGNED_FLAG_OFF:   fl[FLAG_S] = 1'b0;
            OP_OVERFLOW_FLAG_ON:  fl[FLAG_V] = 1'b1;
            OP_OVERFLOW_FLAG_OFF: fl[FLAG_V] = 1'b0;
            OP_TRANSFER_BIT_ON:   fl[FLAG_T] = 1'b1;
            OP_TRANSFER_BIT_OFF:  fl[FLAG_T] = 1'b0;
            OP_HALF_CARRY_ON:     fl[FLAG_H] = 1'b1;
            OP_HALF_CARRY_OFF:    fl[FLAG_H] = 1'b0;
            OP_REGISTER_COPY:     rg[c.rd] = rg[c.rr];
            OP_REGISTER_PAIR_COPY: begin
                rg[c.rd & EVEN_MASK] = rg[c.rr & EVEN_MASK];
                rg[c.rd | 5'h01] = rg[c.rr | 5'h01];
            end
            OP_IMMEDIATE_LOAD:    rg[c.rd] = c.imm[7:0];
            OP_LOAD_INDIRECT, OP_WRITE_INDIRECT: begin
                if (c.mode == AM_PREDEC) p = p - PTR_STEP;
                a = p;
                if (c.mode == AM_POSTINC) p = p + PTR_STEP;
            end
            OP_READ_WITH_OFFSET, OP_WRITE_WITH_OFFSET: a = p + {10'h000, c.imm[5:0]};
            OP_READ_DIRECT, OP_WRITE_DIRECT: a = c.imm;
            OP_PUSH: begin
                a = sp;
                sp = sp - 16'h0001;
            end
            OP_POP: begin
                sp = sp + 16'h0001;
                a = sp;
            end
            OP_PROGRAM_MEMORY_READ: begin
                e.pre = 1'b1;
                e.pa = p;
                e.lat = 4'h3;
                rg[c.use_r0 ? REG_R0 : c.rd] = p[7:0] + p[15:8] + 8'h3c;
                if (c.mode == AM_POSTINC) p = p + PTR_STEP;
            end
            OP_BREAK: e.brk = dbg;
            default: ;
        endcase
        if (c.op inside {OP_LOAD_INDIRECT, OP_WRITE_INDIRECT, OP_PROGRAM_MEMORY_READ})
            {rg[pi + 1], rg[pi]} = p;
        if (ld | st) begin
            e.lat = 4'h2;
            e.addr = a;
            e.re = ld;
            e.we = st;
        end
        if (st) begin
            e.wd = rg[c.rr];
            mir[a] = rg[c.rr];
        end
        if (ld) rg[c.rd] = mir.exists(a) ? mir[a] : (a[7:0] ^ a[15:8] ^ 8'h5a);
        e.flags = fl;
        return e;
    endfunction : ref_exec

    function automatic cfdt_cmd_s mk(input cfdt_op_e op, input logic [4:0] rd,
        input logic [4:0] rr, input logic [15:0] imm, input cfdt_ptr_e ptr,
        input cfdt_mode_e md, input logic u);
        return '{op: op, ptr: ptr, mode: md, use_r0: u, rd: rd, rr: rr, imm: imm};
    endfunction : mk

    // Offers one command and holds it until the unit takes it.
    task automatic issue(input cfdt_cmd_s c);
        logic dbg, r;
        dbg = 1'($urandom_range(0, 1));
        exp_q.push_back(ref_exec(c, dbg));
        cmd <= c;
        cmd_valid <= 1'b1;
        debug_en <= dbg;
        r = 1'b0;
        while (!r) begin
            @(negedge clk);
            r = (ready_q === 1'b1);
            @(posedge clk);
        end
    endtask : issue

    task automatic setp(input logic [4:0] lo, input logic [15:0] v);
        issue(mk(OP_IMMEDIATE_LOAD, lo, 5'h00, {8'h00, v[7:0]}, PTR_X, AM_PLAIN, 1'b0));
        issue(mk(OP_IMMEDIATE_LOAD, lo + 5'h01, 5'h00, {8'h00, v[15:8]}, PTR_X, AM_PLAIN, 1'b0));
    endtask : setp

    ////////////////////////////////////////////////////////////////////////////
    // Watches the outputs and compares each finished command with its note.
    always @(negedge clk) begin
        cfdt_exp_s e;
        int t0;
        if (!rst) begin
            if (dm_q.re === 1'b1 || dm_q.we === 1'b1) begin
                {s_re, s_we, s_addr, s_wd} = {dm_q.re, dm_q.we, dm_q.addr, dm_q.wdata};
            end
            if (pm_re_q === 1'b1) {s_pre, s_pa} = {1'b1, pm_addr_q};
            if (break_q === 1'b1) s_brk = 1'b1;
            if (done_q === 1'b1 && (exp_q.size() == 0 || acc_q.size() == 0)) begin
                check(32'h1, 32'h0);
            end else if (done_q === 1'b1) begin
                e = exp_q.pop_front();
                t0 = acc_q.pop_front();
                check(32'(flags_register_q), 32'(e.flags));
                check(32'(cyc - t0), 32'(e.lat));
                check(32'({s_re, s_we}), 32'({e.re, e.we}));
                if (e.re | e.we) check(32'(s_addr), 32'(e.addr));
                if (e.we) check(32'(s_wd), 32'(e.wd));
                check(32'(s_pre), 32'(e.pre));
                if (e.pre) check(32'(s_pa), 32'(e.pa));
                check(32'(s_brk), 32'(e.brk));
                {s_re, s_we, s_pre, s_brk} = 4'h0;
            end
            if (ready_q === 1'b1 && cmd_valid === 1'b1) acc_q.push_back(cyc);
        end
    end

    // Cycle count with a ceiling against hangs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cfdt_op_e fo [9] = '{OP_SIGNED_FLAG_ON, OP_OVERFLOW_FLAG_ON, OP_TRANSFER_BIT_ON,
            OP_HALF_CARRY_ON, OP_SIGNED_FLAG_OFF, OP_OVERFLOW_FLAG_OFF, OP_TRANSFER_BIT_OFF,
            OP_HALF_CARRY_OFF, OP_INTERRUPTS_OFF};
        cfdt_op_e op;
        cfdt_mode_e md;
        void'($urandom(32'he594));
        foreach (rg[i]) rg[i] = 8'h00;
        fl = FLAGS_RESET;
        sp = SP_TB;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // S, V, T and H each on and off, I off only, others left clear to show they stay put.
        for (int i = 0; i < 13; i++) issue(mk(fo[i % 9], 5'h0, 5'h0, 16'h0, PTR_X, AM_PLAIN, 1'b0));
        for (int i = 0; i < 26; i++) begin
            issue(mk(OP_IMMEDIATE_LOAD, 5'(i), 5'h0, 16'($urandom()), PTR_X, AM_PLAIN, 1'b0));
        end
        setp(REG_X, 16'hffff);
        setp(REG_Y, 16'($urandom()));
        setp(REG_Z, 16'($urandom()));
        // Pointer wraps at both ends of the 16-bit range.
        issue(mk(OP_LOAD_INDIRECT, 5'h03, 5'h0, 16'h0, PTR_X, AM_POSTINC, 1'b0));
        issue(mk(OP_WRITE_INDIRECT, 5'h0, 5'h03, 16'h0, PTR_X, AM_PLAIN, 1'b0));
        issue(mk(OP_WRITE_INDIRECT, 5'h0, 5'h04, 16'h0, PTR_X, AM_PREDEC, 1'b0));
        // Random back-to-back mix of every code, the one unknown code 23 included.
        repeat (300) begin
            op = cfdt_op_e'(5'($urandom_range(0, 23)));
            md = cfdt_mode_e'(2'($urandom_range(0, 2)));
            if (op == OP_PROGRAM_MEMORY_READ) md = cfdt_mode_e'(2'($urandom_range(0, 1)));
            else if (!(op inside {OP_LOAD_INDIRECT, OP_WRITE_INDIRECT})) md = AM_PLAIN;
            issue(mk(op, 5'($urandom_range(0, 25)), 5'($urandom_range(0, 25)),
                16'($urandom()), cfdt_ptr_e'(2'($urandom_range(0, 2))), md,
                1'($urandom_range(0, 1))));
        end
        cmd_valid <= 1'b0;
        for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clk);
        check(32'(exp_q.size()), 32'h0);
        wrap_up();
    end
endmodule : tb_cpu_flag_and_data_transfer_ops
